// >>> wire_link_defs.svh
`ifndef WIRE_LINK_DEFS_SVH
`define WIRE_LINK_DEFS_SVH

// Byte addresses on the processor bus
`define ADDR_IF_CTRL 32'h4000_0506
`define ADDR_ERR_LOW 32'h4000_0508
`define ADDR_ERR_HIGH 32'h4000_0509
`define ADDR_IRQ_STATUS 32'h4000_050A
`define ADDR_IRQ_ENABLE 32'h4000_050B

// digital_interface_control fields
`define CTRL_SPI_EN_BIT 0
`define CTRL_LINK_EN_BIT 2
`define CTRL_XCVR_BIT 3
`define CTRL_FILT_SEL_BIT 4
`define CTRL_WRITE0_BIT 7
`define CTRL_RESET 8'h05
`define CTRL_MASK 8'h9D

// Error flag layout: bits 0..7 low register, 8..9 high register
`define ERR_FLAG_COUNT 10
`define ERR_LOW_MASK 8'hFD
`define ERR_CLR_BIT 7
`define IRQ_BIT 0

// Activation filter timing
`define CLK_HZ 25000000
`define FILTER_LONG_MS 10
`define FILTER_SHORT_MS 1
`define CYCLES_PER_MS (`CLK_HZ / 1000)
`define FILTER_LONG_CYCLES (`FILTER_LONG_MS * `CYCLES_PER_MS)
`define FILTER_SHORT_CYCLES (`FILTER_SHORT_MS * `CYCLES_PER_MS)
`define FILTER_CNT_W 18

`endif

// >>> wire_link_pkg.sv
`include "wire_link_defs.svh"

package wire_link_pkg;

    typedef enum logic [1:0] {
        LINE_IDLE = 2'b01,
        LINE_ACTIVE = 2'b10
    } line_state_t;

    typedef struct packed {
        logic [1:0] sync_r;
        line_state_t state_r;
        logic [`FILTER_CNT_W-1:0] cnt_r;
    } filter_state_t;

    typedef struct packed {
        logic [`ERR_FLAG_COUNT-1:0] flags_r;
    } flag_state_t;

    typedef struct packed {
        logic [7:0] ctrl_r;
        logic irq_flag_r;
        logic irq_en_r;
        logic irq_out_r;
        logic [7:0] rdata_r;
        logic rvalid_r;
    } regs_state_t;

endpackage : wire_link_pkg

// >>> error_flag_bank.sv
`timescale 1ns/1ps
`include "wire_link_defs.svh"

module error_flag_bank
    import wire_link_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [`ERR_FLAG_COUNT-1:0] set_events,
    input wire logic clear_all,
    output logic [`ERR_FLAG_COUNT-1:0] flags
);
    flag_state_t s_r;
    flag_state_t s_nxt;

    // Set beats a simultaneous clear so no event is lost
    always_comb begin
        s_nxt = s_r;
        s_nxt.flags_r = set_events | (s_r.flags_r & ~{`ERR_FLAG_COUNT{clear_all}});
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign flags = s_r.flags_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    set_wins_a: assert property (
        ce && clear_all |=> (flags & $past(set_events)) == $past(set_events))
        else $error("flag event lost during clear");

endmodule : error_flag_bank

// >>> activation_filter.sv
`timescale 1ns/1ps
`include "wire_link_defs.svh"

module activation_filter
    import wire_link_pkg::*;
#(
    parameter int LONG_CYCLES = `FILTER_LONG_CYCLES,
    parameter int SHORT_CYCLES = `FILTER_SHORT_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic enable,
    input wire logic long_sel,
    input wire logic line_in,
    output logic line_active
);
    localparam logic [`FILTER_CNT_W-1:0] LONG_LAST =
        `FILTER_CNT_W'(LONG_CYCLES - 1);
    localparam logic [`FILTER_CNT_W-1:0] SHORT_LAST =
        `FILTER_CNT_W'(SHORT_CYCLES - 1);

    filter_state_t s_r;
    filter_state_t s_nxt;
    logic [`FILTER_CNT_W-1:0] last;
    logic differs;

    assign last = long_sel ? LONG_LAST : SHORT_LAST;
    assign differs = s_r.sync_r[1] != (s_r.state_r == LINE_ACTIVE);

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync_r = {s_r.sync_r[0], line_in};
        if (!enable) begin
            s_nxt.state_r = LINE_IDLE;
            s_nxt.cnt_r = '0;
        end else if (!differs) begin
            // Any bounce restarts the full qualification time
            s_nxt.cnt_r = '0;
        end else if (s_r.cnt_r >= last) begin
            s_nxt.cnt_r = '0;
            unique case (s_r.state_r)
                LINE_IDLE: s_nxt.state_r = LINE_ACTIVE;
                LINE_ACTIVE: s_nxt.state_r = LINE_IDLE;
                default: s_nxt.state_r = LINE_IDLE;
            endcase
        end else begin
            s_nxt.cnt_r = s_r.cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.state_r <= LINE_IDLE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign line_active = (s_r.state_r == LINE_ACTIVE);

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    filter_time_a: assert property (
        // A disable forces idle at once, so only enabled changes count
        $past(enable) && enable && $changed(line_active)
        |-> $past(s_r.cnt_r) >= $past(last))
        else $error("activation changed before filter time");

endmodule : activation_filter

// >>> wire_link_ctrl_status_regs.sv
`timescale 1ns/1ps
`include "wire_link_defs.svh"

// Overview of operation
// - Port enable bit gates serial port
// - Link enable bit gates single-wire link
// - Transceiver bit connects supply, resets off
// - Filter select picks 10 ms or 1 ms
// - Flag low bit0 on slow sync rate
// - Flag low bit2 on short sync stop
// - Flag low bit3 on bad command stop level
// - Flag low bit4 on short command stop
// - Flag low bit5 on bad data stop level
// - Flag low bit6 on short data stop
// - Flag low bit7 on overdriven data stop
// - Flag high bit0 on sync tolerance error
// - Flag high bit1 on unknown command
// - High bit7 write-one clears all flags
// - Interrupt status bit0 reads pending interrupt
// - Writing one clears pending interrupt
// - Interrupt reaches processor only when enabled
module wire_link_ctrl_status_regs
    import wire_link_pkg::*;
#(
    parameter int LONG_CYCLES = `FILTER_LONG_CYCLES,
    parameter int SHORT_CYCLES = `FILTER_SHORT_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic sync_rate_low_error,
    input wire logic sync_stop_short_error,
    input wire logic cmd_stop_level_error,
    input wire logic cmd_stop_short_error,
    input wire logic data_stop_level_error,
    input wire logic data_stop_short_error,
    input wire logic data_stop_overdrive_error,
    input wire logic sync_tolerance_error,
    input wire logic invalid_command_error,
    input wire logic wire_link_irq_event,
    input wire logic line_in,
    output logic spi_enable,
    output logic wire_link_enable,
    output logic wire_transceiver_power,
    output logic activation_filter_select,
    output logic line_active,
    output logic irq
);
    regs_state_t s_r;
    regs_state_t s_nxt;
    logic [`ERR_FLAG_COUNT-1:0] err_set;
    logic [`ERR_FLAG_COUNT-1:0] err_flags;
    logic wr_ctrl;
    logic wr_high;
    logic wr_irq;
    logic wr_irq_en;
    logic error_flags_clear;
    logic [7:0] read_mux;

    function automatic logic hit(input logic [31:0] addr,
                                 input logic [31:0] target);
        hit = (addr == target);
    endfunction : hit

    assign wr_ctrl = reg_wr && hit(reg_addr, `ADDR_IF_CTRL);
    assign wr_high = reg_wr && hit(reg_addr, `ADDR_ERR_HIGH);
    assign wr_irq = reg_wr && hit(reg_addr, `ADDR_IRQ_STATUS);
    assign wr_irq_en = reg_wr && hit(reg_addr, `ADDR_IRQ_ENABLE);
    assign error_flags_clear = wr_high && reg_wdata[`ERR_CLR_BIT];

    // Event vector in register bit order; bit 1 is never set
    assign err_set = {
        invalid_command_error,
        sync_tolerance_error,
        data_stop_overdrive_error,
        data_stop_short_error,
        data_stop_level_error,
        cmd_stop_short_error,
        cmd_stop_level_error,
        sync_stop_short_error,
        1'b0,
        sync_rate_low_error
    };

    error_flag_bank u_flags (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .set_events(err_set),
        .clear_all(error_flags_clear),
        .flags(err_flags)
    );

    // Filter only runs while the link is up and its transceiver powered
    activation_filter #(
        .LONG_CYCLES(LONG_CYCLES),
        .SHORT_CYCLES(SHORT_CYCLES)
    ) u_filter (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .enable(wire_link_enable && wire_transceiver_power),
        .long_sel(activation_filter_select),
        .line_in(line_in),
        .line_active(line_active)
    );

    always_comb begin
        read_mux = 8'h00;
        if (hit(reg_addr, `ADDR_IF_CTRL)) begin
            read_mux = s_r.ctrl_r;
        end else if (hit(reg_addr, `ADDR_ERR_LOW)) begin
            read_mux = err_flags[7:0] & `ERR_LOW_MASK;
        end else if (hit(reg_addr, `ADDR_ERR_HIGH)) begin
            // Clear bit is a strobe and always reads back zero
            read_mux = {6'h00, err_flags[9:8]};
        end else if (hit(reg_addr, `ADDR_IRQ_STATUS)) begin
            read_mux = {7'h00, s_r.irq_flag_r};
        end else if (hit(reg_addr, `ADDR_IRQ_ENABLE)) begin
            read_mux = {7'h00, s_r.irq_en_r};
        end
    end

    always_comb begin
        s_nxt = s_r;
        if (wr_ctrl) begin
            // Bit 7 is kept as written; software owns keeping it 0
            s_nxt.ctrl_r = reg_wdata & `CTRL_MASK;
        end
        if (wr_irq_en) begin
            s_nxt.irq_en_r = reg_wdata[`IRQ_BIT];
        end
        // New event wins over a same-cycle write-one clear
        s_nxt.irq_flag_r = wire_link_irq_event |
            (s_r.irq_flag_r & ~(wr_irq & reg_wdata[`IRQ_BIT]));
        s_nxt.irq_out_r = s_nxt.irq_flag_r & s_nxt.irq_en_r;
        s_nxt.rvalid_r = reg_rd;
        if (reg_rd) begin
            s_nxt.rdata_r = read_mux;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.ctrl_r <= `CTRL_RESET;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign spi_enable = s_r.ctrl_r[`CTRL_SPI_EN_BIT];
    assign wire_link_enable = s_r.ctrl_r[`CTRL_LINK_EN_BIT];
    assign wire_transceiver_power = s_r.ctrl_r[`CTRL_XCVR_BIT];
    assign activation_filter_select = s_r.ctrl_r[`CTRL_FILT_SEL_BIT];
    assign irq = s_r.irq_out_r;
    assign reg_rdata = s_r.rdata_r;
    assign reg_rvalid = s_r.rvalid_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    spi_enable_a: assert property (
        ce && wr_ctrl |=> spi_enable == $past(reg_wdata[`CTRL_SPI_EN_BIT]))
        else $error("serial port enable not taken from write");

    link_enable_a: assert property (
        ce && wr_ctrl
        |=> wire_link_enable == $past(reg_wdata[`CTRL_LINK_EN_BIT]))
        else $error("link enable not taken from write");

    xcvr_power_a: assert property (
        ce && wr_ctrl
        |=> wire_transceiver_power == $past(reg_wdata[`CTRL_XCVR_BIT]))
        else $error("transceiver power not taken from write");

    filter_sel_a: assert property (
        ce && wr_ctrl ##1 !wr_ctrl
        |-> activation_filter_select == $past(reg_wdata[`CTRL_FILT_SEL_BIT], 1)
            ##1 $stable(activation_filter_select))
        else $error("filter select wrong after write");

    sync_rate_a: assert property (
        ce && sync_rate_low_error |=> err_flags[0])
        else $error("sync rate flag not set");

    sync_stop_a: assert property (
        ce && sync_stop_short_error |=> err_flags[2])
        else $error("sync stop flag not set");

    cmd_level_a: assert property (
        ce && cmd_stop_level_error ##1 ce && reg_rd
        && hit(reg_addr, `ADDR_ERR_LOW) |=> reg_rdata[3])
        else $error("command stop level flag not read back");

    cmd_short_a: assert property (
        ce && cmd_stop_short_error |=> err_flags[4])
        else $error("command stop short flag not set");

    data_stop_a: assert property (
        ce && (data_stop_level_error || data_stop_short_error)
        |=> (err_flags[6:5] & $past({data_stop_short_error,
            data_stop_level_error})) != 2'b00)
        else $error("data stop flag not set");

    overdrive_a: assert property (
        ce && data_stop_overdrive_error |=> err_flags[7])
        else $error("overdrive flag not set");

    high_flags_a: assert property (
        ce && reg_rd && hit(reg_addr, `ADDR_ERR_HIGH)
        |=> reg_rvalid && reg_rdata == {6'h00, $past(err_flags[9:8])})
        else $error("high error register read mismatch");

    clear_all_a: assert property (
        ce && error_flags_clear && err_set == '0 |=> err_flags == '0)
        else $error("collective clear left flags set");

    irq_read_a: assert property (
        ce && reg_rd && hit(reg_addr, `ADDR_IRQ_STATUS)
        |=> reg_rdata[0] == $past(s_r.irq_flag_r))
        else $error("interrupt status read mismatch");

    irq_clear_a: assert property (
        ce && wr_irq && reg_wdata[`IRQ_BIT] && !wire_link_irq_event
        |=> !s_r.irq_flag_r && !irq)
        else $error("interrupt not cleared by write one");

    irq_gate_a: assert property (
        irq == (s_r.irq_flag_r && s_r.irq_en_r))
        else $error("interrupt output not gated by enable");

    sticky_a: assert property (
        ce && !error_flags_clear
        |=> (err_flags & $past(err_flags)) == $past(err_flags))
        else $error("error flag dropped without clear");

    ctrl_reset_a: assert property (
        $rose(reset_n) |-> s_r.ctrl_r == `CTRL_RESET)
        else $error("control register not at reset value");

    flags_reset_a: assert property (
        $rose(reset_n) |-> err_flags == '0)
        else $error("error flags not cleared by reset");

    irq_reset_a: assert property (
        $rose(reset_n) |-> !s_r.irq_en_r && !irq)
        else $error("interrupt enable not cleared by reset");

    clear_zero_a: assert property (
        ce && wr_high && !reg_wdata[`ERR_CLR_BIT]
        |=> (err_flags & $past(err_flags)) == $past(err_flags))
        else $error("zero write to clear bit dropped a flag");

    irq_keep_a: assert property (
        ce && wr_irq && !reg_wdata[`IRQ_BIT] && s_r.irq_flag_r
        |=> s_r.irq_flag_r)
        else $error("zero write cleared pending interrupt");

    irq_set_a: assert property (
        ce && wire_link_irq_event |=> s_r.irq_flag_r)
        else $error("interrupt event not recorded");

    irq_mask_a: assert property (
        ce && wr_irq_en && !reg_wdata[`IRQ_BIT] |=> !irq)
        else $error("interrupt passed while disabled");

    ctrl_reserved_a: assert property (
        (s_r.ctrl_r & ~`CTRL_MASK) == 8'h00)
        else $error("reserved control bits not zero");

    low_flags_a: assert property (
        ce && reg_rd && hit(reg_addr, `ADDR_ERR_LOW)
        |=> reg_rdata == ($past(err_flags[7:0]) & `ERR_LOW_MASK))
        else $error("low error register read mismatch");

    link_off_a: assert property (
        ce && !(wire_link_enable && wire_transceiver_power)
        |=> !line_active)
        else $error("line active while link or transceiver off");

    tol_flag_a: assert property (
        ce && sync_tolerance_error |=> err_flags[8])
        else $error("sync tolerance flag not set");

    cmd_code_a: assert property (
        ce && invalid_command_error |=> err_flags[9])
        else $error("invalid command flag not set");

    read_valid_a: assert property (
        ce |=> reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read");

    low_write_a: assert property (
        ce && reg_wr && hit(reg_addr, `ADDR_ERR_LOW)
        |=> (err_flags & $past(err_flags)) == $past(err_flags))
        else $error("write to low error register dropped a flag");

    state_freeze_a: assert property (
        !ce |=> $stable(s_r) && $stable(err_flags))
        else $error("state changed while clock enable low");

    irq_seen_c: cover property (irq);
    clear_seen_c: cover property (err_flags != '0 ##1 error_flags_clear);
    activate_c: cover property ($rose(line_active));
    irq_clear_c: cover property (s_r.irq_flag_r ##1 !s_r.irq_flag_r);
    deactivate_c: cover property (activation_filter_select && $fell(line_active));

endmodule : wire_link_ctrl_status_regs

// >>> wire_host_model.sv
`timescale 1ns/1ps

// Host at the far end of the single-wire link
module wire_host_model (
    input wire logic clk,
    input wire logic dominant,
    output logic line_in
);
    // Released line floats to the pull-up level
    always_ff @(posedge clk) begin
        line_in <= dominant ? 1'b0 : 1'b1;
    end
endmodule : wire_host_model

// >>> testbench.sv
`timescale 1ns/1ps
`include "wire_link_defs.svh"

module testbench;
    import wire_link_pkg::*;
    localparam int SHORT_N = 4;
    localparam int LONG_N = 20;
    typedef struct packed {
        logic [8:0] ev;
        logic [31:0] addr;
        logic [7:0] exp;
    } row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic [31:0] reg_addr = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [8:0] ev = 9'h000;
    logic irq_ev = 1'b0;
    logic dominant = 1'b0;
    logic line_in;
    logic spi_enable, wire_link_enable, wire_transceiver_power;
    logic activation_filter_select, line_active, irq;
    int num_errors = 0;
    int total_checks = 0;
    row_t rows [9];

    wire_link_ctrl_status_regs #(.LONG_CYCLES(LONG_N),
        .SHORT_CYCLES(SHORT_N)) wire_link_ctrl_status_regs_i (
        .clk(clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sync_rate_low_error(ev[0]), .sync_stop_short_error(ev[1]),
        .cmd_stop_level_error(ev[2]), .cmd_stop_short_error(ev[3]),
        .data_stop_level_error(ev[4]), .data_stop_short_error(ev[5]),
        .data_stop_overdrive_error(ev[6]), .sync_tolerance_error(ev[7]),
        .invalid_command_error(ev[8]), .wire_link_irq_event(irq_ev),
        .line_in(line_in), .spi_enable(spi_enable),
        .wire_link_enable(wire_link_enable),
        .wire_transceiver_power(wire_transceiver_power),
        .activation_filter_select(activation_filter_select),
        .line_active(line_active), .irq(irq));

    wire_host_model wire_host_model_i (.clk(clk), .dominant(dominant),
        .line_in(line_in));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic chk(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp,
                seen);
        end
    endtask : chk

    task automatic end_sim;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
        chk("rdata", reg_rdata, exp);
    endtask : rd

    task automatic pulse(input logic [8:0] v, input logic iv);
        @(negedge clk);
        ev = v;
        irq_ev = iv;
        @(negedge clk);
        ev = 9'h000;
        irq_ev = 1'b0;
    endtask : pulse

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    initial begin
        #(40 * 5000);
        num_errors++;
        end_sim();
    end

    initial begin
        for (int i = 0; i < 7; i++) begin
            rows[i] = '{9'h001 << i, `ADDR_ERR_LOW,
                (i == 0) ? 8'h01 : 8'h02 << i};
        end
        rows[7] = '{9'h080, `ADDR_ERR_HIGH, 8'h01};
        rows[8] = '{9'h100, `ADDR_ERR_HIGH, 8'h02};
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        rd(`ADDR_IF_CTRL, 8'h05);
        chk("ports", {5'h00, spi_enable, wire_link_enable,
            wire_transceiver_power}, 8'h06);
        // Each event lands in its own flag; collective clear empties it
        foreach (rows[i]) begin
            pulse(rows[i].ev, 1'b0);
            rd(rows[i].addr, rows[i].exp);
            wr(`ADDR_ERR_HIGH, 8'h80);
            rd(rows[i].addr, 8'h00);
        end
        wr(`ADDR_IF_CTRL, 8'h18);
        chk("ctrl pins", {4'h0, spi_enable, wire_link_enable,
            wire_transceiver_power, activation_filter_select},
            8'h03);
        rd(`ADDR_IF_CTRL, 8'h18);
        // Sticky flags survive a zero write and a low-register write
        pulse(9'h1FF, 1'b0);
        wr(`ADDR_ERR_HIGH, 8'h00);
        wr(`ADDR_ERR_LOW, 8'hFF);
        idle(3);
        rd(`ADDR_ERR_LOW, 8'hFD);
        rd(`ADDR_ERR_HIGH, 8'h03);
        rd(32'h4000_0507, 8'h00);
        ce = 1'b0;
        wr(`ADDR_ERR_HIGH, 8'h80);
        ce = 1'b1;
        rd(`ADDR_ERR_HIGH, 8'h03);
        // Interrupt: pending, masked, unmasked, then cleared
        pulse(9'h000, 1'b1);
        rd(`ADDR_IRQ_STATUS, 8'h01);
        chk("irq masked", {7'h00, irq}, 8'h00);
        wr(`ADDR_IRQ_ENABLE, 8'h01);
        rd(`ADDR_IRQ_ENABLE, 8'h01);
        chk("irq on", {7'h00, irq}, 8'h01);
        wr(`ADDR_IRQ_ENABLE, 8'h00);
        chk("irq remask", {7'h00, irq}, 8'h00);
        wr(`ADDR_IRQ_ENABLE, 8'h01);
        wr(`ADDR_IRQ_STATUS, 8'h00);
        rd(`ADDR_IRQ_STATUS, 8'h01);
        wr(`ADDR_IRQ_STATUS, 8'h01);
        rd(`ADDR_IRQ_STATUS, 8'h00);
        chk("irq off", {7'h00, irq}, 8'h00);
        // Filter: short count to go active, long count to go idle
        wr(`ADDR_IF_CTRL, 8'h0C);
        idle(2);
        chk("filt early", {7'h00, line_active}, 8'h00);
        idle(SHORT_N + 6);
        chk("filt short", {7'h00, line_active}, 8'h01);
        wr(`ADDR_IF_CTRL, 8'h1C);
        dominant = 1'b1;
        idle(SHORT_N + 6);
        chk("filt long hold", {7'h00, line_active}, 8'h01);
        idle(LONG_N);
        chk("filt long", {7'h00, line_active}, 8'h00);
        // Second reset in mid-run
        reset_n = 1'b0;
        idle(2);
        reset_n = 1'b1;
        rd(`ADDR_ERR_HIGH, 8'h00);
        rd(`ADDR_IF_CTRL, 8'h05);
        rd(`ADDR_IRQ_ENABLE, 8'h00);
        end_sim();
    end
endmodule : testbench
